// [inc/ccr_pkg.sv]
package ccr_pkg;
   // register addresses
   localparam logic [7:0] ADDR_CHARGER_CONTROL = 8'h17;
   localparam logic [7:0] ADDR_PIN_CONTROL = 8'h18;
   localparam logic [7:0] ADDR_POWER_PATH = 8'h19;
   // reset values
   localparam logic [7:0] RST_CHARGER_CONTROL = 8'hC9;
   localparam logic [7:0] RST_PIN_CONTROL = 8'hC0;
   localparam logic [7:0] RST_POWER_PATH = 8'h20;
   // writable bits of the power path register
   localparam logic [7:0] MASK_POWER_PATH = 8'hE1;
   // charger control fields
   localparam int RECHG_HI = 7;
   localparam int RECHG_LO = 6;
   localparam int BIT_WD_KICK = 5;
   localparam int BIT_CE_IGNORE = 4;
   localparam int BIT_CHG_WD_VAL = 3;
   localparam int BIT_HIZ = 2;
   localparam int BIT_BAT_SINK = 1;
   localparam int BIT_CHG_EN = 0;
   // pin control fields
   localparam int BIT_ICHG_PIN_EN = 7;
   localparam int BIT_ILIM_PIN_EN = 6;
   localparam int BIT_PG_DIS = 5;
   localparam int BIT_STAT_DIS = 4;
   localparam int BIT_FORCE_D = 3;
   localparam int BIT_FORCE_C = 2;
   localparam int BIT_FORCE_B = 1;
   localparam int BIT_FORCE_A = 0;
   // power path fields
   localparam int BIT_DEFAULTS = 7;
   localparam int BIT_IN_SINK = 6;
   localparam int BIT_PULSE_SKIP = 5;
   localparam int BIT_REVERSE = 0;
   // watchdog timing
   localparam longint CLK_HZ = 100000000;
   localparam longint WD_BASE_S = 40;
   localparam longint WD_BASE_CYCLES = WD_BASE_S * CLK_HZ;
   localparam logic [1:0] WATCHDOG_KICK_CODE = 2'h1;
endpackage : ccr_pkg

// [verilog/ccr_bank.sv]
`timescale 1ns/1ns
// Functional notes
// - bits 7:6 pick recharge threshold 93.0/94.3/95.2/97.6 percent; reset 11
// - writing 1 to watchdog_kick restarts watchdog, bit self-clears; 0 ignored
// - charge_pin_ignore set makes the charge-enable pin ignored; resets 0
// - watchdog expiry loads charge_enable from charge_enable_wd_value; value resets 1
// - high_impedance_enable cleared by register reset, watchdog, adapter plug-in
// - battery_load_sink_enable sinks current; cleared by register reset and watchdog
// - charge_enable enables charge; resets 1, reloaded on watchdog expiry
// - charge_current_pin_enable gates that pin; returns 1 on reset or watchdog
// - input_limit_pin_enable gates that pin; returns 1 on reset or watchdog
// - power_good_pin_disable stops power-good indication; resets 0
// - status_pins_disable stops status a and b functions; resets 0
// - force_status_d pulls pin d low only while charge_pin_ignore set
// - force_status_c pulls pin c low only while power_good_pin_disable set
// - force_status_a/b pull low only while status_pins_disable set
// - register_defaults_restore returns registers to defaults and self-clears
// - input_load_sink_enable cleared by register reset and watchdog
// - pulse_skip_enable resets 1, cleared on valid sync, host may reset
// - pulse skip off selects fixed-frequency light-load; host clears if low termination
// - reverse_mode_enable cleared by register reset, watchdog, adapter plug-in
// - watchdog code 00 off, 01/10/11 give 40/80/160 seconds
module ccr_bank #(
   parameter longint WD_BASE = ccr_pkg::WD_BASE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   input wire logic [1:0] watchdog_code,
   input wire logic adapter_plug_in,
   input wire logic sync_valid,
   input wire logic charge_enable_pin_n,
   input wire logic status_a_normal,
   input wire logic status_b_normal,
   input wire logic power_good_normal,
   output logic charge_active,
   output logic [1:0] recharge_threshold,
   output logic high_impedance_enable,
   output logic battery_load_sink_enable,
   output logic charge_current_pin_enable,
   output logic input_limit_pin_enable,
   output logic input_load_sink_enable,
   output logic pulse_skip_enable,
   output logic reverse_mode_enable,
   output logic watchdog_expired,
   output logic status_output_a_oe_n,
   output logic status_output_b_oe_n,
   output logic status_output_c_pin_oe_n,
   output logic status_output_d_pin_oe_n
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: second and third stages must agree
   logic [3:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
   logic [3:0] sync1_next, sync2_next, sync3_next, pin_next;
   logic [3:0] pins_raw;

   assign pins_raw = {sync_valid, adapter_plug_in, charge_enable_pin_n, 1'b0};

   always_comb
   begin
      sync1_next = pins_raw;
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
      pin_next = pin_reg;
      for (int i = 0; i < 4; i++)
      begin
         if (sync2_reg[i] == sync3_reg[i])
            pin_next[i] = sync3_reg[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync1_reg <= 4'h2; // idle levels, no false edge after reset
         sync2_reg <= 4'h2;
         sync3_reg <= 4'h2;
         pin_reg <= 4'h2;
      end
      else
      begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
         pin_reg <= pin_next;
      end
   end

   logic sync_seen_reg, plug_seen_reg;
   logic sync_rise, plug_rise;
   // rising edges on filtered pins
   assign sync_rise = pin_reg[3] & ~sync_seen_reg;
   assign plug_rise = pin_reg[2] & ~plug_seen_reg;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync_seen_reg <= 1'b0;
         plug_seen_reg <= 1'b0;
      end
      else
      begin
         sync_seen_reg <= pin_reg[3];
         plug_seen_reg <= pin_reg[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog timer
   logic [40:0] wd_cnt_reg, wd_cnt_next;
   logic wd_exp_reg, wd_exp_next;
   logic [40:0] wd_limit;
   logic kick;

   always_comb
   begin
      case (watchdog_code)
         2'h1: wd_limit = 41'(WD_BASE);
         2'h2: wd_limit = 41'(WD_BASE * 2);
         2'h3: wd_limit = 41'(WD_BASE * 4);
         default: wd_limit = 41'h0;
      endcase
   end

   assign kick = wr_en && addr == ccr_pkg::ADDR_CHARGER_CONTROL
                 && wr_data[ccr_pkg::BIT_WD_KICK];

   always_comb
   begin
      wd_cnt_next = wd_cnt_reg + 41'h1;
      wd_exp_next = 1'b0;
      if (watchdog_code == 2'h0 || kick)
         wd_cnt_next = 41'h0;
      else if (wd_cnt_reg >= wd_limit - 41'h1)
      begin
         wd_cnt_next = 41'h0;
         wd_exp_next = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wd_cnt_reg <= 41'h0;
         wd_exp_reg <= 1'b0;
      end
      else
      begin
         wd_cnt_reg <= wd_cnt_next;
         wd_exp_reg <= wd_exp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register bank
   logic [7:0] cc_reg, cc_next, pc_reg, pc_next, pp_reg, pp_next;
   logic [7:0] rd_next;
   logic restore;

   assign restore = wr_en && addr == ccr_pkg::ADDR_POWER_PATH
                    && wr_data[ccr_pkg::BIT_DEFAULTS];

   always_comb
   begin
      cc_next = cc_reg;
      pc_next = pc_reg;
      pp_next = pp_reg;
      if (restore)
      begin
         cc_next = ccr_pkg::RST_CHARGER_CONTROL;
         pc_next = ccr_pkg::RST_PIN_CONTROL;
         pp_next = ccr_pkg::RST_POWER_PATH;
      end
      else
      begin
         if (wr_en && addr == ccr_pkg::ADDR_CHARGER_CONTROL)
            cc_next = wr_data;
         else if (wr_en && addr == ccr_pkg::ADDR_PIN_CONTROL)
            pc_next = wr_data;
         else if (wr_en && addr == ccr_pkg::ADDR_POWER_PATH)
            pp_next = wr_data & ccr_pkg::MASK_POWER_PATH;
         if (sync_rise)
            pp_next[ccr_pkg::BIT_PULSE_SKIP] = 1'b0;
         if (plug_rise)
         begin
            cc_next[ccr_pkg::BIT_HIZ] = 1'b0;
            pp_next[ccr_pkg::BIT_REVERSE] = 1'b0;
         end
         if (wd_exp_reg)
         begin
            cc_next[ccr_pkg::BIT_CHG_EN] = cc_reg[ccr_pkg::BIT_CHG_WD_VAL];
            cc_next[ccr_pkg::BIT_BAT_SINK] = 1'b0;
            cc_next[ccr_pkg::BIT_HIZ] = 1'b0;
            pc_next[ccr_pkg::BIT_ICHG_PIN_EN] = 1'b1;
            pc_next[ccr_pkg::BIT_ILIM_PIN_EN] = 1'b1;
            pp_next[ccr_pkg::BIT_IN_SINK] = 1'b0;
            pp_next[ccr_pkg::BIT_REVERSE] = 1'b0;
         end
      end
      cc_next[ccr_pkg::BIT_WD_KICK] = 1'b0;
      pp_next[ccr_pkg::BIT_DEFAULTS] = 1'b0;
   end

   // read mux
   always_comb
   begin
      rd_next = rd_data;
      if (rd_en)
      begin
         if (addr == ccr_pkg::ADDR_CHARGER_CONTROL)
            rd_next = cc_reg;
         else if (addr == ccr_pkg::ADDR_PIN_CONTROL)
            rd_next = pc_reg;
         else if (addr == ccr_pkg::ADDR_POWER_PATH)
            rd_next = pp_reg;
         else
            rd_next = 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cc_reg <= ccr_pkg::RST_CHARGER_CONTROL;
         pc_reg <= ccr_pkg::RST_PIN_CONTROL;
         pp_reg <= ccr_pkg::RST_POWER_PATH;
         rd_data <= 8'h00;
      end
      else
      begin
         cc_reg <= cc_next;
         pc_reg <= pc_next;
         pp_reg <= pp_next;
         rd_data <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs and pin drive
   logic [15:0] out_reg, out_next;

   always_comb
   begin
      out_next[1:0] = cc_reg[ccr_pkg::RECHG_HI:ccr_pkg::RECHG_LO];
      // pin ignored or low-active pin asserted
      out_next[2] = cc_reg[ccr_pkg::BIT_CHG_EN]
                    & (cc_reg[ccr_pkg::BIT_CE_IGNORE] | ~pin_reg[1]);
      out_next[3] = cc_reg[ccr_pkg::BIT_HIZ];
      out_next[4] = cc_reg[ccr_pkg::BIT_BAT_SINK];
      out_next[5] = pc_reg[ccr_pkg::BIT_ICHG_PIN_EN];
      out_next[6] = pc_reg[ccr_pkg::BIT_ILIM_PIN_EN];
      out_next[7] = pp_reg[ccr_pkg::BIT_IN_SINK];
      out_next[8] = pp_reg[ccr_pkg::BIT_PULSE_SKIP];
      out_next[9] = pp_reg[ccr_pkg::BIT_REVERSE];
      out_next[10] = wd_exp_reg;
      if (pc_reg[ccr_pkg::BIT_STAT_DIS])
      begin
         out_next[11] = ~pc_reg[ccr_pkg::BIT_FORCE_A];
         out_next[12] = ~pc_reg[ccr_pkg::BIT_FORCE_B];
      end
      else
      begin
         out_next[11] = ~status_a_normal;
         out_next[12] = ~status_b_normal;
      end
      if (pc_reg[ccr_pkg::BIT_PG_DIS])
         out_next[13] = ~pc_reg[ccr_pkg::BIT_FORCE_C];
      else
         out_next[13] = ~power_good_normal;
      // pin d forced only when pin ignored
      out_next[14] = ~(cc_reg[ccr_pkg::BIT_CE_IGNORE] & pc_reg[ccr_pkg::BIT_FORCE_D]);
      out_next[15] = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         out_reg <= 16'h7963;
      else
         out_reg <= out_next;
   end

   assign recharge_threshold = out_reg[1:0];
   assign charge_active = out_reg[2];
   assign high_impedance_enable = out_reg[3];
   assign battery_load_sink_enable = out_reg[4];
   assign charge_current_pin_enable = out_reg[5];
   assign input_limit_pin_enable = out_reg[6];
   assign input_load_sink_enable = out_reg[7];
   assign pulse_skip_enable = out_reg[8];
   assign reverse_mode_enable = out_reg[9];
   assign watchdog_expired = out_reg[10];
   assign status_output_a_oe_n = out_reg[11];
   assign status_output_b_oe_n = out_reg[12];
   assign status_output_c_pin_oe_n = out_reg[13];
   assign status_output_d_pin_oe_n = out_reg[14];

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   property p_kick_clear;
      @(posedge clk) disable iff (!rst_n)
         kick |=> !cc_reg[ccr_pkg::BIT_WD_KICK] && wd_cnt_reg == 41'h0;
   endproperty
   a_kick_clear: assert property (p_kick_clear) else $error("kick bit stuck");

   property p_restore;
      @(posedge clk) disable iff (!rst_n)
         restore |=> cc_reg == ccr_pkg::RST_CHARGER_CONTROL && pc_reg == ccr_pkg::RST_PIN_CONTROL
         && pp_reg == ccr_pkg::RST_POWER_PATH;
   endproperty
   a_restore: assert property (p_restore) else $error("defaults not restored");

   property p_wd_chg;
      @(posedge clk) disable iff (!rst_n)
         wd_exp_reg && !restore |=> cc_reg[0] == $past(cc_reg[3]) && !cc_reg[1] && !cc_reg[2];
   endproperty
   a_wd_chg: assert property (p_wd_chg) else $error("watchdog reload wrong");

   property p_wd_pins;
      @(posedge clk) disable iff (!rst_n)
         wd_exp_reg |=> pc_reg[7] && pc_reg[6] && !pp_reg[6] && !pp_reg[0];
   endproperty
   a_wd_pins: assert property (p_wd_pins) else $error("watchdog pin reset wrong");

   property p_reserved;
      @(posedge clk) disable iff (!rst_n) pp_reg[4:1] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_force_d;
      @(posedge clk) disable iff (!rst_n)
         !cc_reg[ccr_pkg::BIT_CE_IGNORE] |=> status_output_d_pin_oe_n;
   endproperty
   a_force_d: assert property (p_force_d) else $error("pin d forced wrongly");

   property p_plug;
      @(posedge clk) disable iff (!rst_n)
         plug_rise && !restore |=> !cc_reg[2] && !pp_reg[0];
   endproperty
   a_plug: assert property (p_plug) else $error("plug-in clear missed");

   property p_sync;
      @(posedge clk) disable iff (!rst_n) sync_rise && !restore |=> !pp_reg[5];
   endproperty
   a_sync: assert property (p_sync) else $error("sync clear missed");

   c_wd: cover property (@(posedge clk) disable iff (!rst_n) wd_exp_reg);
   c_restore: cover property (@(posedge clk) disable iff (!rst_n) restore);
   c_force_a: cover property (@(posedge clk) disable iff (!rst_n) !status_output_a_oe_n);

endmodule : ccr_bank

// [dv/ccr_host.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// host side of the register strobe bus
module ccr_host (
   input wire logic clk,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   // idle bus at time zero
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
   end
   // one write, released at the taking edge; data no longer valid after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~d;
   endtask : wr
   // one read, data taken once the taking edge settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd
endmodule : ccr_host

// [dv/charger_control_register_bank_bench.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// bench top for the charger control registers
module charger_control_register_bank_bench;
   localparam logic [7:0] DFLT [3] = '{8'hC9, 8'hC0, 8'h20};
   logic clk, rst_n, adapter_plug_in, sync_valid, charge_enable_pin_n;
   logic status_a_normal, status_b_normal, power_good_normal;
   logic [1:0] watchdog_code, recharge_threshold;
   logic wr_en, rd_en, charge_active, high_impedance_enable, battery_load_sink_enable;
   logic charge_current_pin_enable, input_limit_pin_enable, input_load_sink_enable;
   logic pulse_skip_enable, reverse_mode_enable, watchdog_expired;
   logic status_output_a_oe_n, status_output_b_oe_n;
   logic status_output_c_pin_oe_n, status_output_d_pin_oe_n;
   logic [7:0] addr, wr_data, rd_data, ctl_out;
   logic [3:0] od;
   int err_count;
   int checks;
   // output bundles for compact compares
   assign ctl_out = {charge_current_pin_enable, input_limit_pin_enable, high_impedance_enable,
      battery_load_sink_enable, input_load_sink_enable, pulse_skip_enable,
      reverse_mode_enable, charge_active};
   assign od = {status_output_d_pin_oe_n, status_output_c_pin_oe_n,
      status_output_b_oe_n, status_output_a_oe_n};
   ccr_bank #(.WD_BASE(100)) u_dut (.clk, .rst_n, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
      .watchdog_code, .adapter_plug_in, .sync_valid, .charge_enable_pin_n, .status_a_normal,
      .status_b_normal, .power_good_normal, .charge_active, .recharge_threshold,
      .high_impedance_enable, .battery_load_sink_enable, .charge_current_pin_enable,
      .input_limit_pin_enable, .input_load_sink_enable, .pulse_skip_enable,
      .reverse_mode_enable, .watchdog_expired, .status_output_a_oe_n, .status_output_b_oe_n,
      .status_output_c_pin_oe_n, .status_output_d_pin_oe_n);
   ccr_host u_host (.clk, .wr_en, .rd_en, .addr, .wr_data, .rd_data);
   ////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (6000) @(posedge clk);
      err_count++;
      $display("[ERR] %0t run did not finish in time", $time);
      finish_test();
   end
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   // defaults, then restore from a dirty state
   task automatic t_restore();
      logic [7:0] d;
      for (int i = 0; i < 3; i++)
      begin
         u_host.rd(8'h17 + 8'(i), d);
         check(d, DFLT[i], "reset value");
      end
      u_host.wr(8'h17, 8'h16);
      u_host.wr(8'h18, 8'h3F);
      u_host.wr(8'h19, 8'hC1);
      for (int i = 0; i < 3; i++)
      begin
         u_host.rd(8'h17 + 8'(i), d);
         check(d, DFLT[i], "after restore");
      end
      repeat (3) @(posedge clk);
      check(ctl_out, 8'hC5, "outputs after restore");
      check({6'h00, recharge_threshold}, 8'h03, "threshold after restore");
      $display("restore test done");
   endtask : t_restore
   // reserved bits, self-clearing kick, unmapped read
   task automatic t_reserved();
      logic [7:0] d;
      u_host.wr(8'h19, 8'h7E);
      u_host.rd(8'h19, d);
      check(d, 8'h60, "reserved bits");
      u_host.wr(8'h17, 8'hE9);
      u_host.rd(8'h17, d);
      check(d, 8'hC9, "kick self clear");
      u_host.rd(8'h55, d);
      check(d, 8'h00, "unmapped read");
      $display("reserved test done");
   endtask : t_reserved
   // charge enable pin gating and threshold codes
   task automatic t_pins();
      localparam logic [7:0] PC [5] = '{8'h00, 8'h0F, 8'h30, 8'h35, 8'h0F};
      localparam logic NRM [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      localparam logic [3:0] OD [5] = '{4'h8, 4'h0, 4'hF, 4'hA, 4'h7};
      for (int i = 0; i < 4; i++)
      begin
         u_host.wr(8'h17, {i[1:0], 1'b0, i[0], 4'h9});
         charge_enable_pin_n <= i[1];
         repeat (8) @(posedge clk);
         check({7'h00, charge_active}, {7'h00, i[0] | ~i[1]}, "charge gating");
         check({6'h00, recharge_threshold}, {6'h00, i[1:0]}, "threshold code");
      end
      for (int i = 0; i < 5; i++)
      begin
         u_host.wr(8'h18, PC[i]);
         status_a_normal <= NRM[i];
         status_b_normal <= NRM[i];
         power_good_normal <= NRM[i];
         repeat (3) @(posedge clk);
         check({4'h0, od}, {4'h0, OD[i]}, "status pins");
      end
      $display("pin test done");
   endtask : t_pins
   // plug-in and sync events
   task automatic t_events();
      logic [7:0] d;
      u_host.wr(8'h17, 8'hCF);
      u_host.wr(8'h19, 8'h61);
      repeat (2) @(posedge clk);
      check(ctl_out, 8'h3E, "outputs before plug-in");
      @(posedge clk);
      adapter_plug_in <= 1'b1;
      repeat (8) @(posedge clk);
      adapter_plug_in <= 1'b0;
      u_host.rd(8'h17, d);
      check(d, 8'hCB, "plug-in clears hiz");
      u_host.rd(8'h19, d);
      check(d, 8'h60, "plug-in clears reverse");
      check(ctl_out, 8'h1C, "outputs after plug-in");
      @(posedge clk);
      sync_valid <= 1'b1;
      repeat (8) @(posedge clk);
      u_host.rd(8'h19, d);
      check(d, 8'h40, "sync clears pulse skip");
      u_host.wr(8'h19, 8'h60);
      u_host.rd(8'h19, d);
      check(d, 8'h60, "host sets pulse skip");
      @(posedge clk);
      sync_valid <= 1'b0;
      $display("event test done");
   endtask : t_events
   // watchdog period per code, kick restart and expiry reloads
   task automatic t_wdog();
      logic [7:0] d;
      logic v;
      int n;
      int p;
      for (int c = 1; c <= 3; c++)
      begin
         v = c[0];
         p = (c == 3) ? 400 : 100 * c;
         @(posedge clk);
         watchdog_code <= c[1:0];
         u_host.wr(8'h18, 8'h00);
         u_host.wr(8'h19, 8'h41);
         repeat (40) @(posedge clk);
         u_host.wr(8'h17, {4'h3, v, 2'h3, ~v});
         n = 0;
         while (watchdog_expired !== 1'b1 && n < 500)
         begin
            @(posedge clk);
            n++;
         end
         watchdog_code <= 2'h0;
         check({7'h00, n >= p - 2 && n <= p + 6}, 8'h01, "watchdog period");
         u_host.rd(8'h17, d);
         check(d, {4'h1, v, 2'h0, v}, "expiry charger control");
         u_host.rd(8'h18, d);
         check(d, 8'hC0, "expiry pin enables");
         u_host.rd(8'h19, d);
         check(d, 8'h00, "expiry power path");
      end
      // code 00 must never expire
      n = 0;
      while (watchdog_expired !== 1'b1 && n < 150)
      begin
         @(posedge clk);
         n++;
      end
      check({7'h00, n == 150}, 8'h01, "watchdog off");
      $display("watchdog test done");
   endtask : t_wdog
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      err_count = 0;
      checks = 0;
      rst_n = 1'b0;
      watchdog_code = 2'h0;
      adapter_plug_in = 1'b0;
      sync_valid = 1'b0;
      charge_enable_pin_n = 1'b0;
      status_a_normal = 1'b0;
      status_b_normal = 1'b0;
      power_good_normal = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_restore();
      t_reserved();
      t_pins();
      t_events();
      t_wdog();
      finish_test();
   end
endmodule : charger_control_register_bank_bench
